// ### rtl/eab_pkg.sv
`default_nettype none
package eab_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_WIDTH  = 8'h00;
    localparam logic [7:0] OFF_STATES = 8'h01;
    localparam logic [7:0] OFF_WAIT_H = 8'h02;
    localparam logic [7:0] OFF_WAIT_L = 8'h03;
    localparam logic [7:0] OFF_BCTRL  = 8'h04;
    localparam logic [7:0] OFF_METHOD = 8'h05;

    localparam logic [7:0] RST_WIDTH  = 8'hff;
    localparam logic [7:0] RST_STATES = 8'hff;
    localparam logic [7:0] RST_WAIT   = 8'hff;
    localparam logic [7:0] RST_BCTRL  = 8'hc6;
    localparam logic [7:0] RST_METHOD = 8'hff;
    localparam logic [7:0] METHOD_RSV = 8'hfe;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    localparam int BCTRL_DIV_BIT = 1;
    localparam int METHOD_BIT    = 0;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam int ADDR_W     = 24;
    localparam int SHIFT_1M   = 17;
    localparam int SHIFT_16M  = 21;
    localparam logic [23:0] ALT_BASE2 = 24'h400000;
    localparam logic [23:0] ALT_BASE3 = 24'hc00000;
    localparam logic [23:0] ALT_BASE4 = 24'he00000;
    localparam logic [23:0] ALT_BASE5 = 24'hfee000;
    localparam logic [23:0] ALT_BASE6 = 24'hfef000;
    localparam logic [23:0] ALT_BASE7 = 24'hff4f00;

    // ------------------------------------------------------------
    // timing in bus states
    // ------------------------------------------------------------
    localparam logic [2:0] INT_STATES = 3'h2;
    localparam logic [2:0] TWO_STATES = 3'h2;
    localparam logic [2:0] THREE_STATES = 3'h3;

    typedef struct packed {
        logic       width8;
        logic       three_state;
        logic [1:0] waits;
    } eab_area_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              internal;
        logic              write;
    } eab_cyc_req_t;

    typedef enum logic [1:0] {
        EAB_IDLE = 2'b00,
        EAB_RUN  = 2'b01
    } eab_state_t;

    // total bus states of one external cycle
    function automatic logic [2:0] eab_states(input eab_area_cfg_t c);
        eab_states = c.three_state ? (THREE_STATES + {1'b0, c.waits}) : TWO_STATES;
    endfunction : eab_states
endpackage : eab_pkg
`default_nettype wire

// ### rtl/eab_area_decode.sv
`timescale 1ns/1ps
`default_nettype none
module eab_area_decode
    import eab_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              mode_16m,
    input  wire logic              uniform,
    output logic      [2:0]        area
);
    always_comb
    begin
        area = addr[SHIFT_1M+2:SHIFT_1M];
        if (mode_16m)
        begin
            area = addr[SHIFT_16M+2:SHIFT_16M];
            // non-uniform split of the 16-Mbyte space
            if (!uniform)
            begin
                if (addr >= ALT_BASE7)
                    area = 3'h7;
                else if (addr >= ALT_BASE6)
                    area = 3'h6;
                else if (addr >= ALT_BASE5)
                    area = 3'h5;
                else if (addr >= ALT_BASE4)
                    area = 3'h4;
                else if (addr >= ALT_BASE3)
                    area = 3'h3;
                else if (addr >= ALT_BASE2)
                    area = 3'h2;
            end
        end
    end
endmodule : eab_area_decode
`default_nettype wire

// ### rtl/eab_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module eab_cycle_timer
    import eab_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [2:0] states,
    output logic            active,
    output logic            done
);
    logic [2:0] remain;

    // counts the states of one bus cycle, last state flagged by done
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            remain <= 3'h0;
            active <= 1'b0;
        end
        else if (clear)
        begin
            remain <= 3'h0;
            active <= 1'b0;
        end
        else if (load)
        begin
            remain <= states - 3'h1;
            active <= 1'b1;
        end
        else if (active)
        begin
            if (remain == 3'h0)
                active <= 1'b0;
            else
                remain <= remain - 3'h1;
        end
    end

    assign done = active && (remain == 3'h0);
endmodule : eab_cycle_timer
`default_nettype wire

// ### rtl/eab_top.sv
// Summary of operation
// - method register reads all ones after reset and hardware standby, kept otherwise
// - upper seven method bits always read one, writes to them ignored
// - method bit 0 selects second update method, 1 the first
// - areas are 128 kbytes in 1-Mbyte modes, 2 Mbytes in 16-Mbyte uniform division
// - areas 0 to 7 lie contiguously upward from address zero
// - one chip select output per area, eight in total
// - in 16-Mbyte modes a control bit picks uniform or alternative division
// - internal accesses use fixed width and fixed states
// - width bit 0 means 16-bit area, 1 means 8-bit area
// - 8-bit bus mode only when all areas are 8-bit
// - state bit 0 gives two states, 1 gives three
// - two-state areas get no wait states
// - three-state areas add 0 to 3 waits from their field
// - only the basic static memory interface exists
// - first method updates address on every bus cycle
// - second method updates address only on external cycles
// - in expanded mode the area select is low during its access
// - all selects stay high for on-chip memory and internal registers
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module eab_top
    import eab_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic              hw_standby,
    input  wire logic              mode_16m,
    input  wire logic              expanded,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [7:0]        reg_rdata,
    input  wire logic              cyc_req,
    input  wire eab_cyc_req_t      cyc_in,
    output logic                   cyc_ready,
    output logic                   cyc_done,
    output logic      [ADDR_W-1:0] ext_addr,
    output logic      [7:0]        area_select_n,
    output logic                   ext_cycle,
    output logic                   cyc_width8,
    output logic      [2:0]        cyc_states,
    output logic                   bus_16bit_mode,
    output logic                   update_method_bit
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]    area_width_register;
    logic [7:0]    area_state_count_register;
    logic [7:0]    wait_count_register_high;
    logic [7:0]    wait_count_register_low;
    logic [7:0]    bus_control_register;
    logic          area_division_select;
    eab_state_t    state;
    eab_state_t    next_state;
    logic [2:0]    cur_area;
    logic [2:0]    req_area;
    eab_area_cfg_t req_cfg;
    logic [2:0]    req_states;
    logic          start;
    logic          t_active;
    logic          t_done;

    assign area_division_select = bus_control_register[BCTRL_DIV_BIT];

    function automatic eab_area_cfg_t area_cfg(input logic [2:0] n);
        logic [15:0] waits;
        waits = {wait_count_register_high, wait_count_register_low};
        area_cfg.width8      = area_width_register[n];
        area_cfg.three_state = area_state_count_register[n];
        area_cfg.waits       = waits[{n, 1'b0} +: 2];
    endfunction : area_cfg

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            area_width_register       <= RST_WIDTH;
            area_state_count_register <= RST_STATES;
            wait_count_register_high  <= RST_WAIT;
            wait_count_register_low   <= RST_WAIT;
            bus_control_register      <= RST_BCTRL;
        end
        else if (hw_standby)
        begin
            area_width_register       <= RST_WIDTH;
            area_state_count_register <= RST_STATES;
            wait_count_register_high  <= RST_WAIT;
            wait_count_register_low   <= RST_WAIT;
            bus_control_register      <= RST_BCTRL;
        end
        else if (reg_we)
        begin
            unique case (reg_addr)
                OFF_WIDTH:  area_width_register       <= reg_wdata;
                OFF_STATES: area_state_count_register <= reg_wdata;
                OFF_WAIT_H: wait_count_register_high  <= reg_wdata;
                OFF_WAIT_L: wait_count_register_low   <= reg_wdata;
                OFF_BCTRL:  bus_control_register      <= reg_wdata;
                default: ;
            endcase
        end
    end

    // method bit, only the low bit is stored
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            update_method_bit <= RST_METHOD[METHOD_BIT];
        else if (hw_standby)
            update_method_bit <= RST_METHOD[METHOD_BIT];
        else if (reg_we && reg_addr == OFF_METHOD)
            update_method_bit <= reg_wdata[METHOD_BIT];
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= RD_UNMAPPED;
        else if (reg_re)
        begin
            unique case (reg_addr)
                OFF_WIDTH:  reg_rdata <= area_width_register;
                OFF_STATES: reg_rdata <= area_state_count_register;
                OFF_WAIT_H: reg_rdata <= wait_count_register_high;
                OFF_WAIT_L: reg_rdata <= wait_count_register_low;
                OFF_BCTRL:  reg_rdata <= bus_control_register;
                OFF_METHOD: reg_rdata <= METHOD_RSV | {7'h00, update_method_bit};
                default:    reg_rdata <= RD_UNMAPPED;
            endcase
        end
        else
            reg_rdata <= RD_UNMAPPED;
    end

    assign bus_16bit_mode = ~&area_width_register;

    // ------------------------------------------------------------
    // bus cycle sequencing
    // ------------------------------------------------------------
    eab_area_decode u_decode (
        .addr     (cyc_in.addr),
        .mode_16m (mode_16m),
        .uniform  (area_division_select),
        .area     (req_area)
    );

    // also re-evaluated when a settings register is written
    always_comb
    begin
        req_cfg = area_cfg(req_area);
    end
    // internal targets ignore the area settings
    assign req_states = cyc_in.internal ? INT_STATES : eab_states(req_cfg);
    assign cyc_ready  = (state == EAB_IDLE);
    assign start      = cyc_req && cyc_ready;

    // only static-memory timing is generated, no other interface type
    eab_cycle_timer u_timer (
        .clk    (clk),
        .resetn (resetn),
        .clear  (hw_standby),
        .load   (start),
        .states (req_states),
        .active (t_active),
        .done   (t_done)
    );

    always_comb
    begin
        next_state = state;
        unique case (state)
            EAB_IDLE: if (start) next_state = EAB_RUN;
            EAB_RUN:  if (t_done) next_state = EAB_IDLE;
            default:  next_state = EAB_IDLE;
        endcase
        if (hw_standby)
            next_state = EAB_IDLE;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= EAB_IDLE;
        else
            state <= next_state;
    end

    assign cyc_done = (state == EAB_RUN) && t_done;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur_area   <= 3'h0;
            cyc_width8 <= 1'b0;
            cyc_states <= 3'h0;
        end
        else if (start)
        begin
            cur_area   <= req_area;
            cyc_width8 <= cyc_in.internal ? 1'b0 : req_cfg.width8;
            cyc_states <= req_states;
        end
    end

    // ------------------------------------------------------------
    // external address and selects
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ext_addr <= '0;
        else if (start && (update_method_bit || !cyc_in.internal))
            ext_addr <= cyc_in.addr;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            area_select_n <= 8'hff;
            ext_cycle     <= 1'b0;
        end
        else if (hw_standby || cyc_done)
        begin
            area_select_n <= 8'hff;
            ext_cycle     <= 1'b0;
        end
        else if (start)
        begin
            ext_cycle     <= !cyc_in.internal;
            area_select_n <= 8'hff;
            if (expanded && !cyc_in.internal)
                area_select_n <= ~(8'h01 << req_area);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] run_len;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            run_len <= 4'h0;
        else if (state == EAB_RUN)
            run_len <= run_len + 4'h1;
        else
            run_len <= 4'h0;
    end

    a_method_reads_ones: assert property (@(posedge clk) disable iff (!resetn)
        ($past(reg_re) && $past(reg_addr) == OFF_METHOD) |-> reg_rdata[7:1] == 7'h7f)
        else $error("reserved method bits not read as one");

    a_standby_init: assert property (@(posedge clk) disable iff (!resetn)
        hw_standby |=> update_method_bit && bus_control_register == RST_BCTRL)
        else $error("standby did not initialise registers");

    a_method_hold: assert property (@(posedge clk) disable iff (!resetn)
        !(reg_we && reg_addr == OFF_METHOD) && !hw_standby |=> $stable(update_method_bit))
        else $error("method bit changed without a write");

    a_cycle_length: assert property (@(posedge clk) disable iff (!resetn)
        cyc_done |-> run_len + 4'h1 == {1'b0, cyc_states})
        else $error("bus cycle length differs from its states");

    a_two_state_nowait: assert property (@(posedge clk) disable iff (!resetn)
        (start && !cyc_in.internal && !req_cfg.three_state) |=> cyc_states == TWO_STATES)
        else $error("wait inserted into two-state area");

    a_internal_fixed: assert property (@(posedge clk) disable iff (!resetn)
        (start && cyc_in.internal) |=> cyc_states == INT_STATES && !cyc_width8)
        else $error("internal access took area settings");

    a_internal_no_cs: assert property (@(posedge clk) disable iff (!resetn)
        (state == EAB_RUN && !ext_cycle) |-> area_select_n == 8'hff)
        else $error("select low on internal access");

    a_one_cs_low: assert property (@(posedge clk) disable iff (!resetn)
        $onehot0(~area_select_n))
        else $error("more than one area select low");

    a_cs_during_ext: assert property (@(posedge clk) disable iff (!resetn)
        (state == EAB_RUN && ext_cycle && expanded) |-> !area_select_n[cur_area])
        else $error("select not held through the access");

    a_cs_bound: assert property (@(posedge clk) disable iff (!resetn)
        (start && !cyc_in.internal) |-> ##[1:6] cyc_done)
        else $error("external access did not end in time");

    a_addr_hold_m2: assert property (@(posedge clk) disable iff (!resetn)
        (start && cyc_in.internal && !update_method_bit) |=> $stable(ext_addr))
        else $error("address moved on internal cycle in second method");

    a_addr_upd_m1: assert property (@(posedge clk) disable iff (!resetn)
        (start && update_method_bit) |=> ext_addr == $past(cyc_in.addr))
        else $error("address not updated in first method");

    a_bus_mode: assert property (@(posedge clk) disable iff (!resetn)
        (area_width_register == 8'hff) == !bus_16bit_mode)
        else $error("bus mode disagrees with area widths");

    a_timer_match: assert property (@(posedge clk) disable iff (!resetn)
        (state == EAB_RUN) == t_active)
        else $error("cycle timer out of step with sequencer");

    a_width_select: assert property (@(posedge clk) disable iff (!resetn)
        (start && !cyc_in.internal) |=> cyc_width8 == $past(area_width_register[req_area]))
        else $error("cycle width does not follow area width bit");

    a_wait_states: assert property (@(posedge clk) disable iff (!resetn)
        (start && !cyc_in.internal && req_cfg.three_state) |=>
            cyc_states == THREE_STATES + {1'b0, $past(req_cfg.waits)})
        else $error("program waits differ from wait field");

    a_area_1m: assert property (@(posedge clk) disable iff (!resetn)
        (start && !mode_16m && expanded && !cyc_in.internal && !hw_standby) |=>
            !area_select_n[$past(cyc_in.addr[SHIFT_1M+2:SHIFT_1M])])
        else $error("wrong select for small area");

    a_area_16m: assert property (@(posedge clk) disable iff (!resetn)
        (start && mode_16m && area_division_select && expanded && !cyc_in.internal && !hw_standby) |=>
            !area_select_n[$past(cyc_in.addr[SHIFT_16M+2:SHIFT_16M])])
        else $error("wrong select for uniform large area");

    a_alt_area2: assert property (@(posedge clk) disable iff (!resetn)
        (start && mode_16m && !area_division_select && expanded && !cyc_in.internal && !hw_standby
            && cyc_in.addr >= ALT_BASE2 && cyc_in.addr < ALT_BASE3) |=> !area_select_n[2])
        else $error("wrong select in alternative division");

    a_cs_release: assert property (@(posedge clk) disable iff (!resetn)
        cyc_done |=> area_select_n == 8'hff && !ext_cycle)
        else $error("select not released after the access");

    a_method_write: assert property (@(posedge clk) disable iff (!resetn)
        (reg_we && reg_addr == OFF_METHOD && !hw_standby) |=> update_method_bit == $past(reg_wdata[METHOD_BIT]))
        else $error("method bit did not take the written value");

    a_internal_no_ext: assert property (@(posedge clk) disable iff (!resetn)
        (start && cyc_in.internal) |=> !ext_cycle)
        else $error("internal access flagged as external");

    a_ext_flag: assert property (@(posedge clk) disable iff (!resetn)
        (start && !cyc_in.internal && !hw_standby) |=> ext_cycle)
        else $error("external access not flagged");
endmodule : eab_top
`default_nettype wire

// ### sim/eab_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// passive static memory on the far side: logs each selection
// ------------------------------------------------------------
module eab_mem_model
    import eab_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        area_select_n,
    input  wire logic              ext_cycle,
    input  wire logic [ADDR_W-1:0] ext_addr,
    output logic      [7:0]        seen_count,
    output logic      [ADDR_W-1:0] seen_addr
);
    logic prev_sel;

    // one count per access: a select falling from the idle level
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prev_sel   <= 1'b0;
            seen_count <= 8'h00;
            seen_addr  <= '0;
        end
        else
        begin
            prev_sel <= ext_cycle && (area_select_n != 8'hff);
            if (ext_cycle && (area_select_n != 8'hff) && !prev_sel)
            begin
                seen_count <= seen_count + 8'h01;
                seen_addr  <= ext_addr;
            end
        end
    end
endmodule : eab_mem_model
`default_nettype wire

// ### sim/eab_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eab_top_tb
    import eab_pkg::*;
;
    logic              clk, resetn, hw_standby, mode_16m, expanded;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, area_select_n, seen_count;
    logic              reg_we, reg_re, cyc_req, cyc_ready, cyc_done, ext_cycle;
    logic              cyc_width8, bus_16bit_mode, update_method_bit;
    eab_cyc_req_t      cyc_in;
    logic [ADDR_W-1:0] ext_addr, seen_addr;
    logic [2:0]        cyc_states;
    int                miscompares, check_count;

    eab_top u_eab_top (.clk(clk), .resetn(resetn), .hw_standby(hw_standby), .mode_16m(mode_16m),
        .expanded(expanded), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .cyc_req(cyc_req), .cyc_in(cyc_in), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
        .ext_addr(ext_addr), .area_select_n(area_select_n), .ext_cycle(ext_cycle), .cyc_width8(cyc_width8),
        .cyc_states(cyc_states), .bus_16bit_mode(bus_16bit_mode), .update_method_bit(update_method_bit));
    eab_mem_model u_eab_mem_model (.clk(clk), .resetn(resetn), .area_select_n(area_select_n),
        .ext_cycle(ext_cycle), .ext_addr(ext_addr), .seen_count(seen_count), .seen_addr(seen_addr));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        @(negedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        @(negedge clk);
        check(reg_rdata, exp, "read data");
    endtask : reg_rd

    task automatic run_cyc(input logic [23:0] a, input logic intl, input logic [7:0] sel,
                           input logic [2:0] st, input logic w8, input logic [23:0] ea);
        int n;
        n = 0;
        @(posedge clk);
        cyc_req <= 1'b1;
        cyc_in  <= '{addr: a, internal: intl, write: 1'b0};
        @(negedge clk);
        check(cyc_ready, 1'b1, "ready before take");
        @(posedge clk);
        cyc_req <= 1'b0;
        do
        begin
            @(negedge clk);
            n++;
        end while (cyc_done !== 1'b1 && n < 9);
        check(n[23:0], st, "cycle length");
        check(cyc_states, st, "states");
        check(area_select_n, sel, "selects");
        check(cyc_width8, w8, "width");
        check(ext_addr, ea, "address");
        check(ext_cycle, !intl, "external flag");
        @(negedge clk);
        check(area_select_n, 8'hff, "selects idle");
    endtask : run_cyc

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_regs();
        reg_rd(OFF_METHOD, 8'hff);
        reg_rd(OFF_BCTRL, 8'hc6);
        reg_rd(8'h3c, 8'h00);
        check(update_method_bit, 1'b1, "method bit");
        check(bus_16bit_mode, 1'b0, "bus mode");
        $display("test reset_regs done");
    endtask : t_reset_regs

    task automatic t_method_reg();
        reg_wr(OFF_METHOD, 8'h00);
        reg_rd(OFF_METHOD, 8'hfe);
        check(update_method_bit, 1'b0, "method bit");
        reg_wr(OFF_METHOD, 8'h01);
        reg_rd(OFF_METHOD, 8'hff);
        $display("test method_reg done");
    endtask : t_method_reg

    task automatic t_areas_1m();
        for (int i = 0; i < 8; i++)
            run_cyc((i << 17) | 24'h000100, 1'b0, ~(8'h01 << i), 3'h6, 1'b1, (i << 17) | 24'h000100);
        check(seen_count, 8'h08, "memory accesses");
        check(seen_addr, 24'he0100, "last memory address");
        $display("test areas_1m done");
    endtask : t_areas_1m

    task automatic t_bus_specs();
        reg_wr(OFF_WIDTH, 8'hfe);
        reg_rd(OFF_WIDTH, 8'hfe);
        check(bus_16bit_mode, 1'b1, "bus mode");
        reg_wr(OFF_STATES, 8'hfd);
        reg_wr(OFF_WAIT_L, 8'h9c);
        run_cyc(24'h000010, 1'b0, 8'hfe, 3'h3, 1'b0, 24'h000010);
        run_cyc(24'h020010, 1'b0, 8'hfd, 3'h2, 1'b1, 24'h020010);
        run_cyc(24'h040010, 1'b0, 8'hfb, 3'h4, 1'b1, 24'h040010);
        run_cyc(24'h060010, 1'b0, 8'hf7, 3'h5, 1'b1, 24'h060010);
        $display("test bus_specs done");
    endtask : t_bus_specs

    task automatic t_internal();
        run_cyc(24'hfff000, 1'b1, 8'hff, INT_STATES, 1'b0, 24'hfff000);
        reg_wr(OFF_METHOD, 8'hfe);
        run_cyc(24'h020020, 1'b0, 8'hfd, 3'h2, 1'b1, 24'h020020);
        run_cyc(24'h0fff00, 1'b1, 8'hff, INT_STATES, 1'b0, 24'h020020);
        $display("test internal done");
    endtask : t_internal

    task automatic t_areas_16m();
        @(posedge clk);
        mode_16m <= 1'b1;
        reg_wr(OFF_WIDTH, 8'hff);
        check(bus_16bit_mode, 1'b0, "bus mode");
        reg_wr(OFF_STATES, 8'hff);
        reg_wr(OFF_WAIT_L, 8'hff);
        for (int i = 0; i < 8; i++)
            run_cyc(i << 21, 1'b0, ~(8'h01 << i), 3'h6, 1'b1, i << 21);
        reg_wr(OFF_BCTRL, 8'hc4);
        run_cyc(24'h200000, 1'b0, 8'hfd, 3'h6, 1'b1, 24'h200000);
        run_cyc(ALT_BASE2, 1'b0, 8'hfb, 3'h6, 1'b1, ALT_BASE2);
        run_cyc(ALT_BASE3, 1'b0, 8'hf7, 3'h6, 1'b1, ALT_BASE3);
        run_cyc(ALT_BASE4, 1'b0, 8'hef, 3'h6, 1'b1, ALT_BASE4);
        run_cyc(ALT_BASE5, 1'b0, 8'hdf, 3'h6, 1'b1, ALT_BASE5);
        run_cyc(ALT_BASE6, 1'b0, 8'hbf, 3'h6, 1'b1, ALT_BASE6);
        run_cyc(ALT_BASE7, 1'b0, 8'h7f, 3'h6, 1'b1, ALT_BASE7);
        $display("test areas_16m done");
    endtask : t_areas_16m

    task automatic t_standby();
        reg_wr(OFF_METHOD, 8'h00);
        @(posedge clk);
        hw_standby <= 1'b1;
        @(posedge clk);
        hw_standby <= 1'b0;
        reg_rd(OFF_METHOD, 8'hff);
        reg_rd(OFF_BCTRL, 8'hc6);
        check(update_method_bit, 1'b1, "method bit");
        $display("test standby done");
    endtask : t_standby

    initial
    begin
        miscompares = 0;
        check_count = 0;
        resetn      = 1'b0;
        hw_standby  = 1'b0;
        mode_16m    = 1'b0;
        expanded    = 1'b1;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_we      = 1'b0;
        reg_re      = 1'b0;
        cyc_req     = 1'b0;
        cyc_in      = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_reset_regs();
        t_method_reg();
        t_areas_1m();
        t_bus_specs();
        t_internal();
        t_areas_16m();
        t_standby();
        give_verdict();
    end

    initial
    begin
        #(8 * 5000);
        miscompares++;
        give_verdict();
    end
endmodule : eab_top_tb
`default_nettype wire
